// ---- include/serdes_pkg.sv ----
package serdes_pkg;
  localparam int DATA_W = 8;
  localparam int TX_FIFO_DEPTH = 32;
  localparam logic [7:0] OFF_SERDES_CTRL = 8'h06;
  localparam logic [7:0] OFF_RX_STATUS = 8'h08;
  localparam logic [7:0] OFF_RX_BYTE_A = 8'h09;
  localparam logic [7:0] OFF_RX_MASK_A = 8'h0A;
  localparam logic [7:0] OFF_RX_BYTE_B = 8'h0B;
  localparam logic [7:0] OFF_RX_MASK_B = 8'h0C;
  localparam logic [7:0] OFF_TX_IRQ_GATE = 8'h0D;
  localparam logic [7:0] OFF_TX_STATUS = 8'h0E;
  localparam logic [7:0] OFF_TX_DATA = 8'h0F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_EOF_LEN = 3'h0;
  localparam logic [3:0] RESET_GATE = 4'h0;
  // receive status layout, per channel c the base is 4*c
  localparam int RXS_FULL = 0;
  localparam int RXS_EOF = 1;
  localparam int RXS_FLOW = 2;
  localparam int RXS_VALID = 3;
  localparam int EOF_LEN_LSB = 0;
  localparam int EOF_LEN_W = 3;
  // transmit status and gate layout
  localparam int TX_EMPTY = 0;
  localparam int TX_DONE = 1;
  localparam int TX_OVERFLOW = 2;
  localparam int TX_UNDERFLOW = 3;
  localparam int TX_FLAG_W = 4;
  // over-the-air bit time
  localparam int BIT_TIME_NS = 16000;
  localparam int CLK_MHZ = 200;
  localparam int BIT_CYCLES = BIT_TIME_NS * CLK_MHZ / 1000;
  localparam int BIT_CNT_W = 12;
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
endpackage

// ---- include/fifo_if.sv ----
`timescale 1ns/100ps
interface fifo_if #(parameter int WIDTH = 8);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport store (input in_valid, output in_ready, input in_data,
                 output out_valid, input out_ready, output out_data);
  modport user (output in_valid, input in_ready, output in_data,
                input out_valid, output out_ready, input out_data);
endinterface

// ---- design/byte_fifo.sv ----
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  fifo_if.store port
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wptr, next_wptr, rptr, next_rptr;
  logic [CW-1:0] cnt, next_cnt;
  logic ovalid, next_ovalid;
  logic [WIDTH-1:0] odata, next_odata;
  logic push, load, pop;

  // the head word sits in a register, so read data never come from the array
  always_comb begin
    push = port.in_valid && (cnt != CW'(DEPTH));
    pop = ovalid && port.out_ready;
    load = (!ovalid || pop) && (cnt != '0);
    next_wptr = push ? PW'(wptr + 1'b1) : wptr;
    next_rptr = load ? PW'(rptr + 1'b1) : rptr;
    next_cnt = CW'(cnt + CW'(push) - CW'(load));
    next_ovalid = load ? 1'b1 : (pop ? 1'b0 : ovalid);
    next_odata = load ? mem[rptr] : odata;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wptr <= '0;
      rptr <= '0;
      cnt <= '0;
      ovalid <= 1'b0;
      odata <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      cnt <= next_cnt;
      ovalid <= next_ovalid;
      odata <= next_odata;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= port.in_data;
    end
  end

  assign port.in_ready = (cnt != CW'(DEPTH));
  assign port.out_valid = ovalid;
  assign port.out_data = odata;
endmodule

// ---- design/radio_serdes_host_regs.sv ----
`timescale 1ns/100ps
// How it works
// - channel b last byte readable at 0x0B, first air bit in bit 0
// - channel a last byte readable at 0x09, lsb first; writes ignored
// - channel a mask at 0x0A marks each valid data bit
// - channel b mask at 0x0C marks each valid data bit
// - status all-valid a set only when every channel a bit valid
// - status all-valid b set only when every channel b bit valid
// - gate bit 3 enables underflow interrupt
// - gate bit 2 enables overflow interrupt
// - gate bit 1 enables done interrupt
// - gate bit 0 enables empty interrupt
// - flow flag on overwrite or empty read; status read clears it
// - idle bit times after start raise end-of-frame, flush partial byte
// - reading transmit status clears underflow, overflow and done
// - transmitted bytes go out bit 0 first through bit 7
module radio_serdes_host_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [serdes_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [serdes_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [1:0] rx_stb,
  input wire logic [1:0] rx_bit,
  input wire logic [1:0] rx_ok,
  output logic tx_bit,
  output logic tx_on,
  output logic tx_fifo_ready,
  output logic tx_irq
);
  import serdes_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic rd_rx_status, rd_tx_status, wr_tx_data;
  logic [2:0] eof_len, next_eof_len;
  logic [TX_FLAG_W-1:0] gate, next_gate;
  logic [7:0] rx_status;
  logic [1:0][7:0] rx_byte, rx_mask;
  logic [7:0] next_rdata;

  assign rd_rx_status = reg_rd && hit(reg_addr, OFF_RX_STATUS);
  assign rd_tx_status = reg_rd && hit(reg_addr, OFF_TX_STATUS);
  assign wr_tx_data = reg_wr && hit(reg_addr, OFF_TX_DATA);

  // receive channels, index 0 is a and 1 is b
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_rx
      logic [7:0] sh, next_sh, msk, next_msk;
      logic [2:0] pos, next_pos, idle, next_idle;
      logic started, next_started;
      logic [7:0] data, next_data, mask, next_mask;
      logic full, next_full, flow, next_flow, eof, next_eof;
      logic all_ok, next_all_ok;
      logic xfer, rd_data;
      logic [7:0] fill_sh, fill_msk;
      always_comb begin
        rd_data = reg_rd && hit(reg_addr, c ? OFF_RX_BYTE_B : OFF_RX_BYTE_A);
        next_sh = sh;
        next_msk = msk;
        next_pos = pos;
        next_idle = idle;
        next_started = started;
        next_eof = eof;
        xfer = 1'b0;
        fill_sh = sh;
        fill_msk = msk;
        if (rx_stb[c]) begin
          fill_sh[pos] = rx_bit[c] & rx_ok[c];
          fill_msk[pos] = rx_ok[c];
          if (rx_ok[c]) begin
            next_started = 1'b1;
            next_idle = '0;
            next_pos = pos + 3'd1;
            next_sh = fill_sh;
            next_msk = fill_msk;
            xfer = (pos == 3'd7);
          end else if (started) begin
            next_idle = idle + 3'd1;
            if (idle == eof_len) begin
              // partial byte moves out, stale bits stay masked off
              next_eof = 1'b1;
              next_started = 1'b0;
              next_idle = '0;
              // with no partial byte the last whole byte is kept
              xfer = (pos != 3'd0);
            end
          end
          if (xfer) begin
            next_pos = '0;
            next_sh = '0;
            next_msk = '0;
          end
        end
        next_data = xfer ? (rx_ok[c] ? fill_sh : sh) : data;
        next_mask = xfer ? (rx_ok[c] ? fill_msk : msk) : mask;
        next_all_ok = xfer ? (&next_mask) : all_ok;
        next_full = xfer ? 1'b1 : (rd_data ? 1'b0 : full);
        next_flow = flow;
        if (rd_rx_status) begin
          next_flow = 1'b0;
          if (!(rx_stb[c] && !rx_ok[c] && started && idle == eof_len)) begin
            next_eof = 1'b0;
          end
        end
        // set wins over the status-read clear
        if ((xfer && full && !rd_data) || (rd_data && !full)) begin
          next_flow = 1'b1;
        end
      end
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          sh <= '0;
          msk <= '0;
          pos <= '0;
          idle <= '0;
          started <= 1'b0;
          data <= RESET_BYTE;
          mask <= RESET_BYTE;
          full <= 1'b0;
          flow <= 1'b0;
          eof <= 1'b0;
          all_ok <= 1'b0;
        end else begin
          sh <= next_sh;
          msk <= next_msk;
          pos <= next_pos;
          idle <= next_idle;
          started <= next_started;
          data <= next_data;
          mask <= next_mask;
          full <= next_full;
          flow <= next_flow;
          eof <= next_eof;
          all_ok <= next_all_ok;
        end
      end
      assign rx_byte[c] = data;
      assign rx_mask[c] = mask;
      assign rx_status[4*c+RXS_FULL] = full;
      assign rx_status[4*c+RXS_EOF] = eof;
      assign rx_status[4*c+RXS_FLOW] = flow;
      assign rx_status[4*c+RXS_VALID] = all_ok;
    end
  endgenerate

  // transmit path: host bytes queue in the fifo ahead of the shifter
  fifo_if #(.WIDTH(DATA_W)) txq ();
  byte_fifo #(.WIDTH(DATA_W), .DEPTH(TX_FIFO_DEPTH)) u_txq (
    .clk(clk),
    .rst_b(rst_b),
    .port(txq.store)
  );

  tx_state_e state, next_state;
  logic [BIT_CNT_W-1:0] div, next_div;
  logic tick;
  logic [7:0] shreg, next_shreg;
  logic [2:0] bitn, next_bitn;
  logic [TX_FLAG_W-1:0] tflag, next_tflag;
  logic next_tx_bit, next_tx_on, next_irq, take, ended;

  assign txq.in_valid = wr_tx_data;
  assign txq.in_data = reg_wdata;
  assign txq.out_ready = take;

  always_comb begin
    tick = (div == BIT_CNT_W'(BIT_CYCLES - 1));
    next_div = tick ? '0 : BIT_CNT_W'(div + 1'b1);
    next_state = state;
    next_shreg = shreg;
    next_bitn = bitn;
    next_tx_bit = tx_bit;
    next_tx_on = tx_on;
    next_tflag = tflag;
    take = 1'b0;
    ended = 1'b0;
    if (tick) begin
      case (state)
        TX_IDLE: begin
          take = txq.out_valid;
        end
        TX_SHIFT: begin
          if (bitn != 3'd7) begin
            next_bitn = bitn + 3'd1;
            next_tx_bit = shreg[bitn + 3'd1];
          end else if (txq.out_valid) begin
            // the next byte follows with no gap
            take = 1'b1;
          end else begin
            ended = 1'b1;
          end
        end
        default: begin
          next_state = TX_IDLE;
        end
      endcase
    end
    if (take) begin
      next_shreg = txq.out_data;
      next_tx_bit = txq.out_data[0];
      next_bitn = '0;
      next_tx_on = 1'b1;
      next_state = TX_SHIFT;
      next_tflag[TX_EMPTY] = 1'b1;
    end
    if (rd_tx_status) begin
      next_tflag[TX_UNDERFLOW] = 1'b0;
      next_tflag[TX_DONE] = 1'b0;
      next_tflag[TX_OVERFLOW] = 1'b0;
    end
    if (ended) begin
      // a status read in the same cycle loses to the new event
      next_tflag[TX_DONE] = 1'b1;
      next_tflag[TX_UNDERFLOW] = 1'b1;
      next_tx_on = 1'b0;
      next_state = TX_IDLE;
    end
    if (wr_tx_data) begin
      // loading the data register re-arms empty, unless a move lands now
      if (!take) begin
        next_tflag[TX_EMPTY] = 1'b0;
      end
      if (!txq.in_ready) begin
        // the refused byte is lost; tx_fifo_ready warns the host
        next_tflag[TX_OVERFLOW] = 1'b1;
      end
    end
    next_irq = |(next_tflag & next_gate);
  end

  always_comb begin
    next_eof_len = eof_len;
    next_gate = gate;
    if (reg_wr && hit(reg_addr, OFF_SERDES_CTRL)) begin
      next_eof_len = reg_wdata[EOF_LEN_LSB +: EOF_LEN_W];
    end
    if (reg_wr && hit(reg_addr, OFF_TX_IRQ_GATE)) begin
      // upper bits are expected zero and are not stored
      next_gate = reg_wdata[TX_FLAG_W-1:0];
    end
    // read data stand until the next read strobe
    next_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        OFF_SERDES_CTRL: next_rdata = {5'h00, eof_len};
        OFF_RX_STATUS: next_rdata = rx_status;
        OFF_RX_BYTE_A: next_rdata = rx_byte[0];
        OFF_RX_MASK_A: next_rdata = rx_mask[0];
        OFF_RX_BYTE_B: next_rdata = rx_byte[1];
        OFF_RX_MASK_B: next_rdata = rx_mask[1];
        OFF_TX_IRQ_GATE: next_rdata = {4'h0, gate};
        OFF_TX_STATUS: next_rdata = {4'h0, tflag};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= TX_IDLE;
      div <= '0;
      shreg <= '0;
      bitn <= '0;
      tflag <= '0;
      tx_bit <= 1'b0;
      tx_on <= 1'b0;
      tx_irq <= 1'b0;
      tx_fifo_ready <= 1'b0;
    end else begin
      state <= next_state;
      div <= next_div;
      shreg <= next_shreg;
      bitn <= next_bitn;
      tflag <= next_tflag;
      tx_bit <= next_tx_bit;
      tx_on <= next_tx_on;
      tx_irq <= next_irq;
      tx_fifo_ready <= txq.in_ready;
    end
  end

  // host register group
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      eof_len <= RESET_EOF_LEN;
      gate <= RESET_GATE;
      reg_rdata <= RESET_BYTE;
    end else begin
      eof_len <= next_eof_len;
      gate <= next_gate;
      reg_rdata <= next_rdata;
    end
  end
endmodule

// ---- dv/serdes_monitor.sv ----
`timescale 1ns/100ps
module serdes_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [serdes_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [serdes_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [1:0] rx_stb,
  input wire logic tx_on,
  input wire logic tx_irq
);
  import serdes_pkg::*;
  localparam logic [7:0] UNMAPPED = 8'h20;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_gate_readback: assert property (
    (reg_wr && reg_addr == OFF_TX_IRQ_GATE) ##1 !reg_wr ##1
    (reg_rd && reg_addr == OFF_TX_IRQ_GATE)
    |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 3))
    else $error("gate readback differs from written value");
  chk_gate_off_irq: assert property (
    (reg_wr && reg_addr == OFF_TX_IRQ_GATE && reg_wdata[3:0] == 4'h0)
    ##1 !reg_wr |=> !tx_irq)
    else $error("irq raised with all gates off");
  chk_txstat_resvd: assert property (
    reg_rd && reg_addr == OFF_TX_STATUS |=> reg_rdata[7:4] == 4'h0)
    else $error("tx status upper bits not zero");
  chk_ovf_clear: assert property (
    (reg_rd && reg_addr == OFF_TX_STATUS && !reg_wr) ##1 !reg_wr ##1
    (reg_rd && reg_addr == OFF_TX_STATUS && !reg_wr)
    |=> !reg_rdata[TX_OVERFLOW])
    else $error("overflow survived a status read");
  chk_rxstat_clear: assert property (
    (reg_rd && reg_addr == OFF_RX_STATUS && rx_stb == 2'h0) ##1
    (rx_stb == 2'h0 && !reg_rd) ##1
    (reg_rd && reg_addr == OFF_RX_STATUS && rx_stb == 2'h0)
    |=> reg_rdata[6:5] == 2'h0 && reg_rdata[2:1] == 2'h0)
    else $error("flow or eof survived a status read");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr == UNMAPPED |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !rst_b |=> reg_rdata == 8'h00 && !tx_on && !tx_irq)
    else $error("outputs not quiet in reset");
endmodule
bind radio_serdes_host_regs serdes_monitor serdes_monitor_inst (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_stb(rx_stb), .tx_on(tx_on), .tx_irq(tx_irq));

// ---- dv/radio_baseband.sv ----
`timescale 1ns/100ps
module radio_baseband (
  input wire logic clk,
  input wire logic tx_bit,
  input wire logic tx_on,
  output logic [1:0] rx_stb,
  output logic [1:0] rx_bit,
  output logic [1:0] rx_ok,
  output logic [7:0] tx_byte,
  output logic tx_got
);
  import serdes_pkg::*;
  logic ok;
  initial begin
    rx_stb = 2'h0;
    rx_bit = 2'h0;
    rx_ok = 2'h0;
    tx_got = 1'b0;
  end
  // lines flip between strobes so stale values are never trusted
  task put(input int ch, input logic b, input logic v);
    @(posedge clk);
    rx_stb[ch] <= 1'b1;
    rx_bit[ch] <= b;
    rx_ok[ch] <= v;
    @(posedge clk);
    rx_stb[ch] <= 1'b0;
    rx_bit[ch] <= ~b;
    rx_ok[ch] <= ~v;
  endtask
  // sample mid bit; a frame cut by reset is not reported
  always @(posedge tx_on) begin
    ok = 1'b1;
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      tx_byte[i] = tx_bit;
      ok = ok & tx_on;
      if (i < 7) repeat (BIT_CYCLES) @(posedge clk);
    end
    tx_got = ok;
    @(posedge clk);
    tx_got = 1'b0;
  end
endmodule

// ---- dv/test_radio_serdes_host_regs.sv ----
`timescale 1ns/100ps
module test_radio_serdes_host_regs;
  import serdes_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_q = 1'b0;
  logic [DATA_W-1:0] reg_rdata, d;
  logic [1:0] rx_stb, rx_bit, rx_ok;
  logic tx_bit, tx_on, tx_fifo_ready, tx_irq, tx_got;
  logic [7:0] tx_byte;
  logic [15:0] rd_exp[$];
  logic [7:0] tx_exp[$];
  int miscompares = 0;
  int comparisons = 0;
  integer seed = 32'h3193;
  always #2.5 clk = ~clk;
  radio_serdes_host_regs radio_serdes_host_regs_inst (.clk(clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_stb(rx_stb), .rx_bit(rx_bit), .rx_ok(rx_ok), .tx_bit(tx_bit),
    .tx_on(tx_on), .tx_fifo_ready(tx_fifo_ready), .tx_irq(tx_irq));
  radio_baseband radio_baseband_inst (.clk(clk), .tx_bit(tx_bit),
    .tx_on(tx_on), .rx_stb(rx_stb), .rx_bit(rx_bit), .rx_ok(rx_ok),
    .tx_byte(tx_byte), .tx_got(tx_got));
  task cmp(input logic [7:0] g, input logic [7:0] e, input logic [7:0] c);
    comparisons++;
    if ((g & c) !== (e & c)) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task final_report;
    if (rd_exp.size() != 0 || tx_exp.size() != 0) miscompares++;
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] c);
    rd_exp.push_back({c, e});
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task wait_on(input logic v);
    int n;
    n = 0;
    while (tx_on !== v) begin
      @(posedge clk);
      n++;
      if (n > 40000) begin
        miscompares++;
        final_report;
      end
    end
  endtask
  // read data is valid the cycle after the strobe edge
  always @(posedge clk) begin
    if (rd_q === 1'b1) begin
      cmp(reg_rdata, rd_exp[0][7:0], rd_exp[0][15:8]);
      void'(rd_exp.pop_front());
    end
    rd_q <= reg_rd;
  end
  always @(posedge tx_got) begin
    cmp(tx_byte, tx_exp[0], 8'hFF);
    void'(tx_exp.pop_front());
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 9; a <= 13; a++) rd(a[7:0], 8'h00, 8'hFF);
    rd(8'h20, 8'h00, 8'hFF);
    rd(OFF_RX_STATUS, 8'h44, 8'hFF);
    wr(OFF_SERDES_CTRL, 8'h01);
    d = 8'($random(seed));
    for (int i = 0; i < 8; i++) begin
      if (i == 4) radio_baseband_inst.put(0, 1'b1, 1'b0);
      radio_baseband_inst.put(0, d[i], 1'b1);
    end
    rd(OFF_RX_STATUS, 8'h09, 8'h0F);
    wr(OFF_RX_MASK_A, 8'h00);
    rd(OFF_RX_MASK_A, 8'hFF, 8'hFF);
    rd(OFF_RX_BYTE_A, d, 8'hFF);
    wr(OFF_RX_BYTE_A, ~d);
    rd(OFF_RX_BYTE_A, d, 8'hFF);
    rd(OFF_RX_STATUS, 8'h04, 8'h07);
    rd(OFF_RX_STATUS, 8'h00, 8'h04);
    d = 8'($random(seed));
    for (int i = 0; i < 5; i++) radio_baseband_inst.put(1, d[i], i < 3);
    rd(OFF_RX_STATUS, 8'h30, 8'hF0);
    rd(OFF_RX_STATUS, 8'h10, 8'h70);
    rd(OFF_RX_MASK_B, 8'h07, 8'hFF);
    rd(OFF_RX_BYTE_B, d, 8'h07);
    d = 8'($random(seed));
    for (int i = 0; i < 8; i++) radio_baseband_inst.put(1, d[i], 1'b1);
    rd(OFF_RX_STATUS, 8'h90, 8'hF0);
    rd(OFF_RX_MASK_B, 8'hFF, 8'hFF);
    rd(OFF_RX_BYTE_B, d, 8'hFF);
    wr(OFF_TX_IRQ_GATE, 8'h0F);
    rd(OFF_TX_IRQ_GATE, 8'h0F, 8'h0F);
    wr(OFF_TX_IRQ_GATE, 8'h00);
    d = 8'($random(seed));
    tx_exp.push_back(d);
    wr(OFF_TX_DATA, d);
    wait_on(1'b1);
    wait_on(1'b0);
    repeat (4) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_TX_IRQ_GATE, 8'h01 << k);
      repeat (2) @(posedge clk);
      cmp(tx_irq, k != 2, 8'h01);
    end
    wr(OFF_TX_IRQ_GATE, 8'h00);
    rd(OFF_TX_STATUS, 8'h0B, 8'hFF);
    rd(OFF_TX_STATUS, 8'h01, 8'hFF);
    // flood faster than the shifter drains to force an overflow
    wr(OFF_TX_IRQ_GATE, 8'h04);
    for (int i = 0; i < 36; i++) begin
      d = 8'($random(seed));
      wr(OFF_TX_DATA, d);
    end
    cmp(tx_fifo_ready, 1'b0, 8'h01);
    repeat (2) @(posedge clk);
    cmp(tx_irq, 1'b1, 8'h01);
    rd(OFF_TX_STATUS, 8'h04, 8'h04);
    rd(OFF_TX_STATUS, 8'h00, 8'h04);
    repeat (3) @(posedge clk);
    cmp(tx_irq, 1'b0, 8'h01);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFF_TX_IRQ_GATE, 8'h00, 8'hFF);
    repeat (2) @(posedge clk);
    final_report;
  end
endmodule
